// *** hdl/pssp_pkg.sv ***
package pssp_pkg;
	timeunit 1ns;
	timeprecision 1ps;

	// Organisation: 512K words of 36 bits, four 9-bit byte lanes
	localparam int unsigned ADDR_W   = 19;
	localparam int unsigned DATA_W   = 36;
	localparam int unsigned LANES    = 4;
	localparam int unsigned LANE_W   = 9;
	localparam int unsigned DEPTH    = 524288;

	// Burst counter spans the two low address bits
	localparam int unsigned BURST_W  = 2;

	// Pipeline depth from address edge to data edge, in enabled edges
	localparam int unsigned DATA_LAT = 2;

	// Reset values of the control pipeline
	localparam logic [ADDR_W-1:0]  RST_ADDR  = 19'h00000;
	localparam logic [LANES-1:0]   RST_LANE  = 4'h0;
	localparam logic [BURST_W-1:0] RST_BURST = 2'h0;
	localparam logic [DATA_W-1:0]  RST_DATA  = 36'h000000000;

	// Operation carried down the pipeline, Gray order idle-read-write
	typedef enum logic [1:0] {
		PSSP_IDLE  = 2'h0,
		PSSP_READ  = 2'h1,
		PSSP_WRITE = 2'h3
	} pssp_op_t;

endpackage : pssp_pkg

// *** hdl/pssp_port.sv ***
// Behaviour
// - Address, selects, write controls and write data land in input registers.
// - Read data leaves the data pins from clocked output registers.
// - Clock qualify high freezes every register and the storage array.
// - Active-low write strobe writes; per-lane selects choose stored bytes.
// - Selected only when select one low, two high, three low.
// - Output enable high forces data pins undriven at once, no clock.
// - Drivers switched off synchronously during the data phase of writes.
// - Driver turn-on and turn-off follow the pipeline while output enable is held low.
// - Any read/write mix accepted on consecutive cycles, no wait states.
// - Storage holds 524288 words of 36 bits at the registered address.
// - Burst advance makes addresses internally, linear or interleaved order.
module pssp_port
	import pssp_pkg::*;
(
	input  wire logic              clock,                // 250 MHz bus clock
	input  wire logic              resetn,               // Async reset, low
	input  wire logic              clock_qualify_n,      // Low lets edges act
	input  wire logic [ADDR_W-1:0] addr,                 // Word address
	input  wire logic              burst_advance,        // High continues burst
	input  wire logic              burst_interleave,     // High interleaved
	input  wire logic              write_n,              // Write strobe, low
	input  wire logic              byte_lane_write_a_n,  // Lane a, bits 8:0
	input  wire logic              byte_lane_write_b_n,  // Lane b, bits 17:9
	input  wire logic              byte_lane_write_c_n,  // Lane c, bits 26:18
	input  wire logic              byte_lane_write_d_n,  // Lane d, bits 35:27
	input  wire logic              chip_sel_1_n,         // Select one, low
	input  wire logic              chip_sel_2,           // Select two, high
	input  wire logic              chip_sel_3_n,         // Select three, low
	input  wire logic              output_enable_n,      // Async drive enable
	input  wire logic [DATA_W-1:0] dq_in,                // Data pin level
	output logic      [DATA_W-1:0] dq_out,               // Data pin drive
	output logic                   dq_oe                 // High drives pins
);
	timeunit 1ns;
	timeprecision 1ps;

	// Expand lane enables to a bit mask
	function automatic logic [DATA_W-1:0] lane_mask(
		input logic [LANES-1:0] lanes
	);
		logic [DATA_W-1:0] m;
		m = '0;
		for (int i = 0; i < LANES; i++) begin
			m[i*LANE_W +: LANE_W] = {LANE_W{lanes[i]}};
		end
		return m;
	endfunction : lane_mask

	// Merge new bytes over an old word by lane
	function automatic logic [DATA_W-1:0] lane_merge(
		input logic [DATA_W-1:0] old_w,
		input logic [DATA_W-1:0] new_w,
		input logic [LANES-1:0]  lanes
	);
		logic [DATA_W-1:0] m;
		m = lane_mask(lanes);
		return (new_w & m) | (old_w & ~m);
	endfunction : lane_merge

	// Next burst address from base and count
	function automatic logic [ADDR_W-1:0] burst_addr(
		input logic [ADDR_W-1:0]  base,
		input logic [BURST_W-1:0] cnt,
		input logic               ilv
	);
		logic [BURST_W-1:0] low;
		low = ilv ? (base[BURST_W-1:0] ^ cnt)
		          : BURST_W'(base[BURST_W-1:0] + cnt);
		return {base[ADDR_W-1:BURST_W], low};
	endfunction : burst_addr

	logic [DATA_W-1:0] mem [DEPTH];

	logic               qual_en;
	logic               selected;

	pssp_op_t           s1_op_r,    s1_op_nxt;
	logic [ADDR_W-1:0]  s1_addr_r,  s1_addr_nxt;
	logic [LANES-1:0]   s1_lane_r,  s1_lane_nxt;
	logic [ADDR_W-1:0]  base_r,     base_nxt;
	logic [BURST_W-1:0] cnt_r,      cnt_nxt;

	pssp_op_t           s2_op_r,    s2_op_nxt;
	logic [ADDR_W-1:0]  s2_addr_r,  s2_addr_nxt;
	logic [LANES-1:0]   s2_lane_r,  s2_lane_nxt;

	logic               wr_r,       wr_nxt;
	logic [ADDR_W-1:0]  wr_addr_r,  wr_addr_nxt;
	logic [LANES-1:0]   wr_lane_r,  wr_lane_nxt;
	logic [DATA_W-1:0]  din_r,      din_nxt;

	logic [DATA_W-1:0]  dout_r,     dout_nxt;
	logic               oe_r,       oe_nxt;
	logic [DATA_W-1:0]  rd_word;

	assign qual_en  = ~clock_qualify_n;
	assign selected = ~chip_sel_1_n & chip_sel_2 & ~chip_sel_3_n;

	// Address stage: load a new access or step the running burst
	always_comb begin
		s1_op_nxt   = s1_op_r;
		s1_addr_nxt = s1_addr_r;
		s1_lane_nxt = s1_lane_r;
		base_nxt    = base_r;
		cnt_nxt     = cnt_r;
		if (qual_en) begin
			if (burst_advance && s1_op_r != PSSP_IDLE) begin
				cnt_nxt     = BURST_W'(cnt_r + 2'h1);
				s1_addr_nxt = burst_addr(base_r, cnt_nxt, burst_interleave);
			end else if (!burst_advance && selected) begin
				s1_op_nxt   = write_n ? PSSP_READ : PSSP_WRITE;
				s1_addr_nxt = addr;
				base_nxt    = addr;
				cnt_nxt     = RST_BURST;
			end else begin
				s1_op_nxt   = PSSP_IDLE;
			end
			// lanes sampled each cycle, so a burst may vary bytes
			s1_lane_nxt = ~{byte_lane_write_d_n, byte_lane_write_c_n,
			                byte_lane_write_b_n, byte_lane_write_a_n};
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s1_op_r   <= PSSP_IDLE;
			s1_addr_r <= RST_ADDR;
			s1_lane_r <= RST_LANE;
			base_r    <= RST_ADDR;
			cnt_r     <= RST_BURST;
		end else begin
			s1_op_r   <= s1_op_nxt;
			s1_addr_r <= s1_addr_nxt;
			s1_lane_r <= s1_lane_nxt;
			base_r    <= base_nxt;
			cnt_r     <= cnt_nxt;
		end
	end

	// Second stage aligns the access with its data cycle
	always_comb begin
		s2_op_nxt   = s2_op_r;
		s2_addr_nxt = s2_addr_r;
		s2_lane_nxt = s2_lane_r;
		if (qual_en) begin
			s2_op_nxt   = s1_op_r;
			s2_addr_nxt = s1_addr_r;
			s2_lane_nxt = s1_lane_r;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s2_op_r   <= PSSP_IDLE;
			s2_addr_r <= RST_ADDR;
			s2_lane_r <= RST_LANE;
		end else begin
			s2_op_r   <= s2_op_nxt;
			s2_addr_r <= s2_addr_nxt;
			s2_lane_r <= s2_lane_nxt;
		end
	end

	// A write committed this edge is forwarded so a read right behind
	// it never sees stale storage; this is what makes hold
	always_comb begin
		rd_word = mem[s2_addr_r];
		if (wr_r && wr_addr_r == s2_addr_r) begin
			rd_word = lane_merge(rd_word, din_r, wr_lane_r);
		end
	end

	// Data stage: write data captured, read data loaded, drivers steered
	always_comb begin
		wr_nxt      = wr_r;
		wr_addr_nxt = wr_addr_r;
		wr_lane_nxt = wr_lane_r;
		din_nxt     = din_r;
		dout_nxt    = dout_r;
		oe_nxt      = oe_r;
		if (qual_en) begin
			din_nxt     = dq_in;
			wr_nxt      = (s2_op_r == PSSP_WRITE);
			wr_addr_nxt = s2_addr_r;
			wr_lane_nxt = s2_lane_r;
			if (s2_op_r == PSSP_READ) begin
				dout_nxt = rd_word;
			end
			oe_nxt      = (s2_op_r == PSSP_READ);
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wr_r      <= 1'b0;
			wr_addr_r <= RST_ADDR;
			wr_lane_r <= RST_LANE;
			din_r     <= RST_DATA;
			dout_r    <= RST_DATA;
			oe_r      <= 1'b0;
		end else begin
			wr_r      <= wr_nxt;
			wr_addr_r <= wr_addr_nxt;
			wr_lane_r <= wr_lane_nxt;
			din_r     <= din_nxt;
			dout_r    <= dout_nxt;
			oe_r      <= oe_nxt;
		end
	end

	// Storage commit one edge after the data is captured; the array has
	// no reset, its contents are undefined at power-up
	// word storage
	always_ff @(posedge clock) begin
		if (qual_en && wr_r) begin
			mem[wr_addr_r] <= lane_merge(mem[wr_addr_r], din_r, wr_lane_r);
		end
	end

	// Pin drive; output enable gates without a clock
	assign dq_out = dout_r;
	assign dq_oe  = oe_r & ~output_enable_n;

endmodule : pssp_port

// *** sim/pssp_port_props.sv ***
module pssp_port_props
	import pssp_pkg::*;
(
	input wire logic              clock,           // Clock
	input wire logic              resetn,          // Reset
	input wire logic              clock_qualify_n, // Freeze
	input wire logic              burst_advance,   // Burst
	input wire logic              write_n,         // Write
	input wire logic              chip_sel_1_n,    // Select
	input wire logic              chip_sel_2,      // Select
	input wire logic              chip_sel_3_n,    // Select
	input wire logic              output_enable_n, // Drive
	input wire logic [DATA_W-1:0] dq_out,          // Data
	input wire logic              dq_oe            // Enable
);
	timeunit 1ns;
	timeprecision 1ps;
	// Decoded loads, so each property reads as a pipeline walk
	logic go, sel, rd, wr, ds;
	assign go  = !clock_qualify_n;
	assign sel = !chip_sel_1_n && chip_sel_2 && !chip_sel_3_n;
	assign rd  = go && !burst_advance && sel && write_n;
	assign wr  = go && !burst_advance && sel && !write_n;
	assign ds  = go && !burst_advance && !sel;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	property p_off; output_enable_n |-> !dq_oe; endproperty
	a_off: assert property (p_off) else $error("drive while disabled");
	property p_rd; rd ##1 go ##1 go |=> dq_oe != output_enable_n; endproperty
	a_rd: assert property (p_rd) else $error("read data late");
	property p_wr; wr ##1 go ##1 go |=> !dq_oe; endproperty
	a_wr: assert property (p_wr) else $error("drive in write");
	property p_ds; ds ##1 go ##1 go |=> !dq_oe; endproperty
	a_ds: assert property (p_ds) else $error("drive unselected");
	property p_frz; clock_qualify_n |=> $stable(dq_out); endproperty
	a_frz: assert property (p_frz) else $error("frozen data moved");
	property p_on; $rose(dq_oe) && $stable(output_enable_n) |-> $past(go);
	endproperty
	a_on: assert property (p_on) else $error("turn-on unclocked");
	property p_b2b; wr ##1 rd ##1 go ##1 go |-> !dq_oe ##1
		(dq_oe != output_enable_n); endproperty
	a_b2b: assert property (p_b2b) else $error("turnaround lost");
	property p_bst; rd ##1 (go && burst_advance) [*3] ##1 go [*2] |=>
		dq_oe != output_enable_n; endproperty
	a_bst: assert property (p_bst) else $error("burst beat lost");
endmodule : pssp_port_props

// *** sim/pssp_ctrl_model.sv ***
module pssp_ctrl_model
	import pssp_pkg::*;
(
	input wire logic              clock,           // Clock
	input wire logic              clock_qualify_n, // Freeze
	input wire logic [ADDR_W-1:0] addr,            // Address
	input wire logic              wr_ld,           // Write load
	output logic      [DATA_W-1:0] dq_in            // Data drive
);
	timeunit 1ns;
	timeprecision 1ps;
	logic              wr1_r = 1'b0;
	logic [ADDR_W-1:0] a1_r;
	initial dq_in = 36'h000000000;
	// data follows by two enabled edges; frozen edges hold all
	always @(posedge clock) begin
		if (!clock_qualify_n) begin
			wr1_r <= wr_ld;
			a1_r  <= addr;
			// Released bus toggles so stale data never looks valid
			dq_in <= wr1_r ? {a1_r[16:0], a1_r} : ~dq_in;
		end
	end
endmodule : pssp_ctrl_model

// *** sim/tb_top.sv ***
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pssp_pkg::*;
	localparam logic [5:0] RD = 6'h0A, WR = 6'h02, ID = 6'h0B;
	localparam logic [5:0] AD = 6'h1A, FZ = 6'h2B;
	localparam logic [ADDR_W-1:0] Z = 19'h00000;
	logic              clock = 1'b0, resetn = 1'b0, bi = 1'b0, oen = 1'b0;
	logic [5:0]        k = ID;
	logic [3:0]        ln = 4'h0;
	logic [ADDR_W-1:0] a = Z;
	logic [DATA_W-1:0] dq_in, dq_out;
	logic              dq_oe, wr_ld;
	int                n_mismatch = 0, checks = 0;
	// Clock and write-load decode for the controller model
	initial forever #2 clock = ~clock;
	// controller stores only on a selected write load
	assign wr_ld = !k[4] && !k[3] && k[2:0] == 3'h2;
	pssp_port uut (.clock(clock), .resetn(resetn), .clock_qualify_n(k[5]),
		.addr(a), .burst_advance(k[4]), .burst_interleave(bi),
		.write_n(k[3]), .byte_lane_write_a_n(ln[0]),
		.byte_lane_write_b_n(ln[1]), .byte_lane_write_c_n(ln[2]),
		.byte_lane_write_d_n(ln[3]), .chip_sel_1_n(k[0]),
		.chip_sel_2(k[1]), .chip_sel_3_n(k[2]), .output_enable_n(oen),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
	pssp_ctrl_model pm (.clock(clock), .clock_qualify_n(k[5]), .addr(a),
		.wr_ld(wr_ld), .dq_in(dq_in));
	task t(logic [5:0] kk, logic [ADDR_W-1:0] aa);
		@(posedge clock);
		k <= kk;
		a <= aa;
	endtask : t
	function logic [DATA_W-1:0] p(logic [ADDR_W-1:0] x);
		return {x[16:0], x};
	endfunction : p
	task chk(string n, logic [DATA_W-1:0] s, e);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// Looks once the launching edge has settled
	task c(logic eo, logic [DATA_W-1:0] ed);
		@(negedge clock);
		chk("dq_oe", {35'h0, dq_oe}, {35'h0, eo});
		if (eo) chk("dq_out", dq_out, ed);
	endtask : c
	// write, read, write, read with no gaps
	task s_b2b;
		for (int i = 0; i < 4; i++) t(i[0] ? RD : WR, 19'h10 << i[1]);
		c(0, Z);
		t(ID, Z);
		c(1, p(19'h00010));
		t(ID, Z);
		c(0, Z);
		t(ID, Z);
		c(1, p(19'h00020));
	endtask : s_b2b
	// lane a left out keeps its old unknown content
	task s_lane;
		t(WR, 19'h7FFFF);
		ln <= 4'h1;
		t(ID, Z);
		ln <= 4'h0;
		t(ID, Z);
		t(RD, 19'h7FFFF);
		repeat (3) t(ID, Z);
		c(1, {27'h7FFFFFF, 9'hXX});
		// Reload a known word: frozen-data checks compare the pins
		// against their past value, and an unknown lane never matches
		t(RD, 19'h00010);
		repeat (3) t(ID, Z);
		c(1, p(19'h00010));
	endtask : s_lane
	// frozen edges push the read data out
	task s_frz;
		t(RD, 19'h00020);
		t(FZ, Z);
		t(FZ, Z);
		c(0, Z);
		repeat (2) t(ID, Z);
		c(0, Z);
		t(ID, Z);
		c(1, p(19'h00020));
	endtask : s_frz
	// disable wins over a pending read beat
	task s_oe;
		t(RD, 19'h00010);
		repeat (3) t(ID, Z);
		oen <= 1'b1;
		c(0, Z);
		t(ID, Z);
		oen <= 1'b0;
	endtask : s_oe
	// each select off in turn blocks the read
	task s_sel;
		for (int i = 0; i < 3; i++) begin
			t(RD ^ 6'(1 << i), 19'h00010);
			repeat (3) t(ID, Z);
			c(0, Z);
		end
	endtask : s_sel
	// base 9, linear then interleaved order
	task s_bst;
		for (int i = 0; i < 4; i++) t(WR, 19'h8 | 19'(i));
		repeat (2) t(ID, Z);
		for (int m = 0; m < 2; m++) begin
			t(RD, 19'h00009);
			bi <= m[0];
			repeat (3) t(AD, Z);
			for (int j = 0; j < 4; j++) begin
				if (j > 0) t(ID, Z);
				c(1, p(19'h8 | 19'(m ? 1 ^ j : (1 + j) % 4)));
			end
		end
	endtask : s_bst
	task complete_run;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run
	// Main sequence after a 12-cycle reset
	initial begin
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		s_b2b;
		s_lane;
		s_frz;
		s_oe;
		s_sel;
		s_bst;
		complete_run;
	end
	// Watchdog: the run needs well under 200 cycles
	initial begin
		#20000;
		n_mismatch++;
		complete_run;
	end
endmodule : tb_top
bind pssp_port pssp_port_props chk_i (.clock(clock), .resetn(resetn),
	.clock_qualify_n(clock_qualify_n), .burst_advance(burst_advance),
	.write_n(write_n), .chip_sel_1_n(chip_sel_1_n), .chip_sel_2(chip_sel_2),
	.chip_sel_3_n(chip_sel_3_n), .output_enable_n(output_enable_n),
	.dq_out(dq_out), .dq_oe(dq_oe));
